// file: verilog/monitor_pins_pkg.sv
// Package of offsets, fields, reset values and timing for the monitor pin logic
package monitor_pins_pkg;

  // Register offsets
  localparam logic [7:0] CONFIG_ADDR     = 8'h40;
  localparam logic [7:0] RESET_CTRL_ADDR = 8'h44;
  localparam logic [7:0] CI_CLEAR_ADDR   = 8'h46;
  localparam logic [7:0] PIN_STATUS_ADDR = 8'h4F;

  // Configuration register fields
  localparam int CFG_INT_EN_BIT    = 1;
  localparam int CFG_RST_GO_BIT    = 4;
  localparam int CFG_CI_CLEAR_BIT  = 6;

  // Reset control and intrusion clear fields
  localparam int RST_OUT_EN_BIT    = 7;
  localparam int CI_CLEAR_BIT      = 7;

  // Pin status fields
  localparam int STAT_STRAP_LSB    = 0;
  localparam int STAT_INT_BIT      = 2;
  localparam int STAT_CI_PULSE_BIT = 3;
  localparam int STAT_RST_PULSE_BIT = 4;
  localparam int STAT_TEST_BIT     = 5;
  localparam int STAT_CI_LEVEL_BIT = 6;

  // Reset values and read data of unmapped addresses and bits
  localparam logic [7:0] CONFIG_RESET     = 8'h00;
  localparam logic [7:0] RESET_CTRL_RESET = 8'h00;
  localparam logic [7:0] CI_CLEAR_RESET   = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA    = 8'h00;

  // Timing
  localparam int unsigned CLOCK_KHZ      = 250000;
  localparam int unsigned PULSE_MIN_MS   = 20;
  localparam int unsigned PULSE_CYCLES   = PULSE_MIN_MS * CLOCK_KHZ;
  localparam int          PULSE_CNT_W    = 23;

  // Pulse channels
  localparam int CH_RESET     = 0;
  localparam int CH_INTRUSION = 1;
  localparam int NUM_CH       = 2;

endpackage : monitor_pins_pkg

// file: verilog/pulse_if.sv
// Interface between pin control and a low-pulse timer
`timescale 1ns/100ps
`default_nettype none
interface pulse_if;
  logic start;
  logic active;
  modport timer (input start, output active);
  modport ctrl  (output start, input active);
endinterface : pulse_if
`default_nettype wire

// file: verilog/low_pulse_timer.sv
// Minimum-width low pulse timer for an open-drain pin
`timescale 1ns/100ps
`default_nettype none
module low_pulse_timer
  import monitor_pins_pkg::*;
#(
  parameter int unsigned LEN = PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // Control side
  pulse_if.timer    pif
);

  localparam logic [PULSE_CNT_W-1:0] LOAD = PULSE_CNT_W'(LEN - 1);

  logic [PULSE_CNT_W-1:0] count;

  // Hold active for LEN cycles, then release
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pif.active <= 1'b0;
      count      <= '0;
    end else if (!pif.active) begin
      if (pif.start) begin
        pif.active <= 1'b1;
        count      <= LOAD;
      end
    end else if (count == '0) begin
      pif.active <= 1'b0;
    end else begin
      count <= count - 1'b1;
    end
  end

endmodule : low_pulse_timer
`default_nettype wire

// file: verilog/monitor_control_pin_logic.sv
// Pin-level control logic of the hardware monitor: straps, interrupt, intrusion, reset, test
`timescale 1ns/100ps
`default_nettype none
module monitor_control_pin_logic
  import monitor_pins_pkg::*;
#(
  parameter int unsigned PULSE_LEN = PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  // Address straps
  input  wire logic       addr_strap_low_test_out_in,
  output var  logic       addr_strap_low_test_out_out,
  output var  logic       addr_strap_low_test_out_oe,
  input  wire logic       addr_strap_high,
  output var  logic [1:0] serial_addr_low,
  // Serial bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe,
  input  wire logic       sda_pull_req,
  // Fan tach inputs, part of the test chain
  input  wire logic       tach_input_one,
  input  wire logic       tach_input_two,
  // Intrusion line
  input  wire logic       intrusion_line_in,
  output var  logic       intrusion_line_out,
  output var  logic       intrusion_line_oe,
  output var  logic       intrusion_seen,
  // Interrupt pin
  input  wire logic       irq_req,
  output var  logic       int_n_out,
  output var  logic       int_n_oe,
  // Master reset pin
  input  wire logic       reset_n_pin_in,
  output var  logic       reset_n_pin_out,
  output var  logic       reset_n_pin_oe,
  output var  logic       soft_rstn,
  // Test mode pin
  input  wire logic       test_mode_in_analog_out,
  output var  logic       analog_out_en
);

  // Register decode shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  // NAND chain over the pins under test
  function automatic logic nand_chain(input logic [5:0] v);
    logic acc;
    acc = 1'b1;
    for (int i = 0; i < 6; i++) begin
      acc = ~(acc & v[i]);
    end
    nand_chain = acc;
  endfunction : nand_chain

  // Internal state
  logic       int_rstn;
  logic       drive_guard;
  logic       strap_taken;
  logic [1:0] strap;
  logic       int_en;
  logic       rst_go;
  logic       cfg_ci_clear;
  logic       rst_out_en;
  logic       reg_ci_clear;
  logic       test_mode;
  logic       ci_level;
  logic       chain_result;
  logic       ci_req;
  logic       rst_req;
  logic [7:0] next_rdata;

  pulse_if pif [NUM_CH] ();

  // Timers for the reset and intrusion-clear pulses
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_timer
      low_pulse_timer #(
        .LEN (PULSE_LEN)
      ) u_timer (
        .clock (clock),
        .rstn  (int_rstn),
        .pif   (pif[g])
      );
    end
  endgenerate

  assign ci_req  = cfg_ci_clear | reg_ci_clear;
  assign rst_req = rst_out_en & rst_go;

  assign pif[CH_INTRUSION].start = ci_req;
  assign pif[CH_RESET].start     = rst_req;

  // Pin reset, ignored while the device itself drives the pin
  always_ff @(posedge clock) begin
    if (!rstn) begin
      int_rstn    <= 1'b0;
      drive_guard <= 1'b0;
    end else begin
      drive_guard <= reset_n_pin_oe;
      int_rstn    <= reset_n_pin_in | reset_n_pin_oe | drive_guard;
    end
  end

  // Reset to the rest of the chip
  always_ff @(posedge clock) begin
    if (!rstn) begin
      soft_rstn <= 1'b0;
    end else begin
      soft_rstn <= int_rstn;
    end
  end

  // Strap capture after reset release
  always_ff @(posedge clock) begin
    if (!int_rstn) begin
      strap_taken <= 1'b0;
      strap       <= 2'h0;
    end else if (!strap_taken && !test_mode) begin
      strap_taken <= 1'b1;
      strap       <= {addr_strap_high, addr_strap_low_test_out_in};
    end
  end

  always_ff @(posedge clock) begin
    if (!int_rstn) begin
      serial_addr_low <= 2'h0;
    end else begin
      serial_addr_low <= strap;
    end
  end

  // Configuration register
  always_ff @(posedge clock) begin
    if (!int_rstn) begin
      int_en       <= CONFIG_RESET[CFG_INT_EN_BIT];
      rst_go       <= CONFIG_RESET[CFG_RST_GO_BIT];
      cfg_ci_clear <= CONFIG_RESET[CFG_CI_CLEAR_BIT];
    end else if (reg_wr && hit(reg_addr, CONFIG_ADDR)) begin
      int_en       <= reg_wdata[CFG_INT_EN_BIT];
      rst_go       <= reg_wdata[CFG_RST_GO_BIT];
      cfg_ci_clear <= reg_wdata[CFG_CI_CLEAR_BIT];
    end else begin
      if (pif[CH_RESET].active) begin
        rst_go <= 1'b0;
      end
      if (pif[CH_INTRUSION].active) begin
        cfg_ci_clear <= 1'b0;
      end
    end
  end

  // Reset output enable register
  always_ff @(posedge clock) begin
    if (!int_rstn) begin
      rst_out_en <= RESET_CTRL_RESET[RST_OUT_EN_BIT];
    end else if (reg_wr && hit(reg_addr, RESET_CTRL_ADDR)) begin
      rst_out_en <= reg_wdata[RST_OUT_EN_BIT];
    end
  end

  // Intrusion clear register
  always_ff @(posedge clock) begin
    if (!int_rstn) begin
      reg_ci_clear <= CI_CLEAR_RESET[CI_CLEAR_BIT];
    end else if (reg_wr && hit(reg_addr, CI_CLEAR_ADDR)) begin
      reg_ci_clear <= reg_wdata[CI_CLEAR_BIT];
    end else if (pif[CH_INTRUSION].active) begin
      reg_ci_clear <= 1'b0;
    end
  end

  // Test mode and intrusion level sampling
  always_ff @(posedge clock) begin
    if (!int_rstn) begin
      test_mode    <= 1'b0;
      ci_level     <= 1'b0;
      chain_result <= 1'b0;
    end else begin
      test_mode    <= test_mode_in_analog_out;
      ci_level     <= intrusion_line_in & ~intrusion_line_oe;
      chain_result <= nand_chain({scl_in, sda_in, tach_input_one, tach_input_two,
                                  intrusion_line_in, addr_strap_high});
    end
  end

  always_ff @(posedge clock) begin
    if (!int_rstn) begin
      intrusion_seen <= 1'b0;
    end else begin
      intrusion_seen <= ci_level;
    end
  end

  // Analogue output only outside test mode
  always_ff @(posedge clock) begin
    if (!int_rstn) begin
      analog_out_en <= 1'b0;
    end else begin
      analog_out_en <= ~test_mode;
    end
  end

  // Low strap pin as test chain output
  always_ff @(posedge clock) begin
    if (!int_rstn) begin
      addr_strap_low_test_out_oe  <= 1'b0;
      addr_strap_low_test_out_out <= 1'b0;
    end else begin
      addr_strap_low_test_out_oe  <= test_mode;
      addr_strap_low_test_out_out <= chain_result;
    end
  end

  // Serial data, pull-down only
  always_ff @(posedge clock) begin
    if (!int_rstn) begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe  <= sda_pull_req;
    end
  end

  // Interrupt pin, open drain
  always_ff @(posedge clock) begin
    if (!int_rstn) begin
      int_n_out <= 1'b0;
      int_n_oe  <= 1'b0;
    end else begin
      int_n_out <= 1'b0;
      int_n_oe  <= int_en & irq_req;
    end
  end

  // Intrusion line clear pulse, open drain
  always_ff @(posedge clock) begin
    if (!int_rstn) begin
      intrusion_line_out <= 1'b0;
      intrusion_line_oe  <= 1'b0;
    end else begin
      intrusion_line_out <= 1'b0;
      intrusion_line_oe  <= pif[CH_INTRUSION].active;
    end
  end

  // Reset pin pulse, open drain
  always_ff @(posedge clock) begin
    if (!int_rstn) begin
      reset_n_pin_out <= 1'b0;
      reset_n_pin_oe  <= 1'b0;
    end else begin
      reset_n_pin_out <= 1'b0;
      reset_n_pin_oe  <= pif[CH_RESET].active;
    end
  end

  // Read mux
  always_comb begin
    next_rdata = UNMAPPED_DATA;
    if (hit(reg_addr, CONFIG_ADDR)) begin
      next_rdata[CFG_INT_EN_BIT]   = int_en;
      next_rdata[CFG_RST_GO_BIT]   = rst_go;
      next_rdata[CFG_CI_CLEAR_BIT] = cfg_ci_clear;
    end else if (hit(reg_addr, RESET_CTRL_ADDR)) begin
      next_rdata[RST_OUT_EN_BIT] = rst_out_en;
    end else if (hit(reg_addr, CI_CLEAR_ADDR)) begin
      next_rdata[CI_CLEAR_BIT] = reg_ci_clear;
    end else if (hit(reg_addr, PIN_STATUS_ADDR)) begin
      next_rdata[STAT_STRAP_LSB +: 2]  = strap;
      next_rdata[STAT_INT_BIT]         = int_n_oe;
      next_rdata[STAT_CI_PULSE_BIT]    = pif[CH_INTRUSION].active;
      next_rdata[STAT_RST_PULSE_BIT]   = pif[CH_RESET].active;
      next_rdata[STAT_TEST_BIT]        = test_mode;
      next_rdata[STAT_CI_LEVEL_BIT]    = ci_level;
    end
  end

  // Read data in the cycle after the strobe only
  always_ff @(posedge clock) begin
    if (!int_rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : monitor_control_pin_logic
`default_nettype wire

// file: verif/monitor_pins_sva.sv
// Checker of pin behaviour at the monitor pin logic ports
`timescale 1ns/100ps
`default_nettype none
module monitor_pins_sva
  import monitor_pins_pkg::*;
#(
  parameter int unsigned PULSE_LEN = PULSE_CYCLES
) (
  // Clock, reset and bus
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  // Serial and interrupt
  input wire logic       sda_pull_req,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       irq_req,
  input wire logic       int_n_out,
  input wire logic       int_n_oe,
  // Intrusion and reset pins
  input wire logic       intrusion_line_in,
  input wire logic       intrusion_line_out,
  input wire logic       intrusion_line_oe,
  input wire logic       intrusion_seen,
  input wire logic       reset_n_pin_in,
  input wire logic       reset_n_pin_out,
  input wire logic       reset_n_pin_oe,
  // Test mode
  input wire logic       test_mode_in_analog_out,
  input wire logic       addr_strap_low_test_out_oe,
  input wire logic       analog_out_en
);
  logic [2:0]  up;
  logic [31:0] rcnt;
  logic [31:0] ccnt;

  // Cycles since any reset
  always_ff @(posedge clock) begin
    if (!rstn || !reset_n_pin_in) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
  end

  // Pulse widths
  always_ff @(posedge clock) begin
    rcnt <= reset_n_pin_oe ? rcnt + 32'h1 : 32'h0;
    ccnt <= intrusion_line_oe ? ccnt + 32'h1 : 32'h0;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence ci_wr_s;
    reg_wr && reg_addr == CI_CLEAR_ADDR && reg_wdata[CI_CLEAR_BIT];
  endsequence

  sequence int_off_s;
    reg_wr && reg_addr == CONFIG_ADDR && !reg_wdata[CFG_INT_EN_BIT];
  endsequence

  AST_SDA: assert property (up > 3'h1 |-> !sda_out && sda_oe == $past(sda_pull_req))
    else $error("data line drive wrong");
  AST_INT: assert property (!irq_req |=> !int_n_oe)
    else $error("interrupt pulled without request");
  AST_INT_OFF: assert property (int_off_s |-> ##2 !int_n_oe)
    else $error("interrupt pulled while disabled");
  AST_OD: assert property (!intrusion_line_out && !reset_n_pin_out && !int_n_out)
    else $error("open drain pin driven high");
  AST_RST_LEN: assert property ($fell(reset_n_pin_oe) |-> rcnt == PULSE_LEN)
    else $error("reset pulse width wrong");
  AST_CI_LEN: assert property ($fell(intrusion_line_oe) |-> ccnt == PULSE_LEN)
    else $error("intrusion clear width wrong");
  AST_MAX: assert property (rcnt <= PULSE_LEN && ccnt <= PULSE_LEN)
    else $error("pulse too long");
  AST_CI_GO: assert property ((up > 3'h4 && !intrusion_line_oe) ##0 ci_wr_s |-> ##3 intrusion_line_oe)
    else $error("intrusion clear not started");
  AST_TEST: assert property (up > 3'h3 |-> addr_strap_low_test_out_oe == $past(test_mode_in_analog_out, 2) && analog_out_en == !addr_strap_low_test_out_oe)
    else $error("test mode pins wrong");
  AST_CI_SEEN: assert property ((up > 3'h5 && !intrusion_line_oe) [*3] |-> intrusion_seen == $past(intrusion_line_in, 2))
    else $error("intrusion level not seen");
endmodule : monitor_pins_sva
bind monitor_control_pin_logic monitor_pins_sva #(.PULSE_LEN(PULSE_LEN)) chk (.*);
`default_nettype wire

// file: verif/board_model.sv
// Board model: reset network with pull-up and intrusion latch
`timescale 1ns/100ps
`default_nettype none
module board_model (
  // Clock and device drives
  input  wire logic clock,
  input  wire logic rst_oe,
  input  wire logic ci_oe,
  // Bench controls
  input  wire logic ext_pull,
  input  wire logic tamper,
  // Resolved pins
  output var  logic rst_pin,
  output var  logic ci_pin
);
  logic latch = 1'b0;
  always @(posedge clock) begin
    if (ci_oe) latch <= 1'b0;
    else if (tamper) latch <= 1'b1;
  end
  assign rst_pin = !(rst_oe || ext_pull);
  assign ci_pin = latch && !ci_oe;
endmodule : board_model
`default_nettype wire

// file: verif/test_monitor_control_pin_logic.sv
// Testbench of the monitor pin logic
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module test_monitor_control_pin_logic;
  import monitor_pins_pkg::*;
  localparam int unsigned LEN = 8;
  logic clock, rstn, reg_wr, reg_rd, addr_strap_high, scl_in, sda_in, sda_pull_req;
  logic tach_input_one, tach_input_two, irq_req, test_mode_in_analog_out, strap0;
  logic ext_pull, tamper, addr_strap_low_test_out_in, addr_strap_low_test_out_out;
  logic addr_strap_low_test_out_oe, sda_out, sda_oe, intrusion_line_in, intrusion_line_out;
  logic intrusion_line_oe, intrusion_seen, int_n_out, int_n_oe, reset_n_pin_in;
  logic reset_n_pin_out, reset_n_pin_oe, soft_rstn, analog_out_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] serial_addr_low;
  logic [7:0] mdl [256];
  int         n_fail = 0;
  int         checks = 0;
  int         n;

  assign addr_strap_low_test_out_in = addr_strap_low_test_out_oe ?
                                      addr_strap_low_test_out_out : strap0;
  monitor_control_pin_logic #(.PULSE_LEN(LEN)) dut (.*);
  board_model bm (
    .clock    (clock),
    .rst_oe   (reset_n_pin_oe),
    .ci_oe    (intrusion_line_oe),
    .ext_pull (ext_pull),
    .tamper   (tamper),
    .rst_pin  (reset_n_pin_in),
    .ci_pin   (intrusion_line_in)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = !clock;
  end

  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      CONFIG_ADDR:     return 8'h52;
      RESET_CTRL_ADDR: return 8'h80;
      CI_CLEAR_ADDR:   return 8'h80;
      default:         return 8'h00;
    endcase
  endfunction : wmask

  // Expected test chain result, NAND chain from the high strap onward
  function automatic logic chain_exp();
    logic [5:0] v;
    logic       a;
    v = {scl_in, sda_in, tach_input_one, tach_input_two, intrusion_line_in, addr_strap_high};
    a = 1'b1;
    for (int i = 0; i < 6; i++) a = !(a & v[i]);
    return a;
  endfunction : chain_exp

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    mdl[a] = d & wmask(a);
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    `CHK("rdata", mdl[a], reg_rdata)
  endtask : rd

  task automatic meas(input bit ci, output int cnt);
    cnt = 0;
    repeat (40) begin
      @(posedge clock);
      #1;
      if (ci ? intrusion_line_oe === 1'b1 : reset_n_pin_in === 1'b0) cnt++;
    end
  endtask : meas

  task automatic report_and_stop();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #100000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    {rstn, reg_wr, reg_rd, addr_strap_high, scl_in, sda_in, sda_pull_req, tach_input_one,
     tach_input_two, irq_req, test_mode_in_analog_out, strap0, ext_pull, tamper} = '0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    mdl = '{default: 8'h00};
    void'($urandom(32'h45d6));
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    rd(CONFIG_ADDR);
    rd(RESET_CTRL_ADDR);
    rd(CI_CLEAR_ADDR);
    wr(8'h55, 8'hFF);
    rd(8'h55);
    for (int en = 1; en >= 0; en--) begin
      wr(CONFIG_ADDR, en[0] ? 8'h02 : 8'h00);
      repeat (20) begin
        @(posedge clock);
        {irq_req, sda_pull_req, scl_in, sda_in, tach_input_one, tach_input_two} <= 6'($urandom);
        @(posedge clock);
        #1;
        `CHK("int_oe", en[0] & irq_req, int_n_oe)
        `CHK("sda_oe", sda_pull_req, sda_oe)
      end
    end
    for (int s = 0; s < 4; s++) begin
      wr(CONFIG_ADDR, 8'h02);
      @(posedge clock);
      {addr_strap_high, strap0} <= 2'(s);
      ext_pull <= 1'b1;
      repeat (3) @(posedge clock);
      ext_pull <= 1'b0;
      #1;
      `CHK("soft_rstn", 1'b0, soft_rstn)
      mdl = '{default: 8'h00};
      repeat (4) @(posedge clock);
      #1;
      `CHK("strap", 2'(s), serial_addr_low)
      `CHK("soft_rstn", 1'b1, soft_rstn)
      rd(CONFIG_ADDR);
      mdl[PIN_STATUS_ADDR] = 8'(s);
      rd(PIN_STATUS_ADDR);
    end
    wr(CONFIG_ADDR, 8'h10);
    meas(1'b0, n);
    `CHK("rst_off", 0, n)
    wr(CONFIG_ADDR, 8'h00);
    wr(RESET_CTRL_ADDR, 8'h80);
    wr(CONFIG_ADDR, 8'h10);
    meas(1'b0, n);
    `CHK("rst_len", LEN, n)
    rd(RESET_CTRL_ADDR);
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      tamper <= 1'b1;
      @(posedge clock);
      tamper <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
      `CHK("seen", 1'b1, intrusion_seen)
      if (k == 0) wr(CI_CLEAR_ADDR, 8'h80);
      else wr(CONFIG_ADDR, 8'h40);
      meas(1'b1, n);
      `CHK("ci_len", LEN, n)
      `CHK("seen", 1'b0, intrusion_seen)
    end
    for (int t = 3; t >= 0; t--) begin
      @(posedge clock);
      test_mode_in_analog_out <= t[1];
      {scl_in, sda_in, tach_input_one, tach_input_two} <= 4'($urandom);
      repeat (3) @(posedge clock);
      #1;
      `CHK("test_oe", t[1], addr_strap_low_test_out_oe)
      `CHK("aout", !t[1], analog_out_en)
      `CHK("chain", chain_exp(), addr_strap_low_test_out_out)
    end
    report_and_stop();
  end
endmodule : test_monitor_control_pin_logic
`default_nettype wire
